// >>> hw/cbsmse_exec.sv
`timescale 1ns/1ns
// Overview of operation
// - Branch when zero clear: program counter plus sign-extended doubled offset.
// - Branch with zero set leaves the program counter on the next instruction.
// - Branch reach is minus 512 to plus 511 words, full 20-bit range.
// - Branches leave flags and mode bits untouched.
// - Copy writes source to destination, changes no flags or mode bits.
// - Idle does nothing and keeps every flag.
// - Pull reads at stack pointer, adds two, then writes destination.
// - Pull always steps the stack pointer by two, byte or word.
// - Byte pull into a register clears the upper byte.
// - Push lowers stack pointer by two, then stores operand there.
// - Byte push writes only the low byte of the stack word.
// - Subroutine exit loads low 16 pc bits, clears top four, steps pointer.
// - Interrupt exit first pops status word, also giving pc bits 19:16.
// - Interrupt exit then pops pc bits 15:0 and steps pointer again.
// - Interrupt exit restores all flags and mode bits from the stack.
// - After interrupt exit execution resumes at the saved address.
// - Left shift by one, old msb into carry, zero into lsb.
// - Word shift overflow set for 4000h up to below C000h.
// - Byte shift overflow set for 40h up to below C0h.
// - Shift sets negative and zero from the result, mode bits kept.
module cbsmse_exec (
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_resetn,
  input  wire logic                    i_cmd_valid,
  input  wire cbsmse_pkg::cbsmse_cmd_s i_cmd,
  output logic                         o_cmd_ready,
  output logic                         o_done,
  output cbsmse_pkg::cbsmse_mem_s      o_mem,
  input  wire logic                    i_mem_ack,
  input  wire logic [15:0]             i_mem_rdata,
  input  wire logic [3:0]              i_rd_sel,
  output logic [15:0]                  o_rd_data,
  output logic [19:0]                  o_program_counter,
  output logic [19:0]                  o_stack_pointer,
  output logic [15:0]                  o_status_word
);

  typedef struct packed {
    cbsmse_pkg::cbsmse_state_e st;
    logic [19:0]               pc;
    logic [19:0]               sp;
    logic [15:0]               sr;
    logic [11:0][15:0]         regs;
    cbsmse_pkg::cbsmse_cmd_s   cmd;
    cbsmse_pkg::cbsmse_mem_s   mem;
    logic [3:0]                hi_pc;
    logic                      done;
    logic [15:0]               rd_data;
  } cbsmse_core_s;

  cbsmse_core_s q;
  cbsmse_core_s n;
  logic         acc;
  logic [19:0]  jump_ofs;
  logic [15:0]  sh_res;
  logic         sh_ovf;
  logic [3:0]   rd_idx;

  // Only one operation is in flight, so the core waits while the bus is busy.
  assign o_cmd_ready = (q.st == cbsmse_pkg::ST_IDLE);
  assign acc         = i_cmd_valid & o_cmd_ready;
  assign rd_idx      = i_rd_sel - cbsmse_pkg::REG_GP0;

  // The doubled offset is sign extended to the full address width.
  assign jump_ofs = {{9{i_cmd.offset[9]}}, i_cmd.offset, 1'b0};

  // Shift result and overflow, byte results keep the upper byte clear.
  always_comb begin
    if (i_cmd.byte_w) begin
      sh_res = {8'h00, i_cmd.dst_val[6:0], 1'b0};
      sh_ovf = (i_cmd.dst_val[7:0] >= cbsmse_pkg::OVF_B_LO) &&
               (i_cmd.dst_val[7:0] < cbsmse_pkg::OVF_B_HI);
    end else begin
      sh_res = {i_cmd.dst_val[14:0], 1'b0};
      sh_ovf = (i_cmd.dst_val >= cbsmse_pkg::OVF_W_LO) &&
               (i_cmd.dst_val < cbsmse_pkg::OVF_W_HI);
    end
  end

  // Writes a value to the destination of the latched command.
  function automatic cbsmse_core_s put_dst(cbsmse_core_s s, logic [15:0] v);
    logic [15:0] val;
    logic [3:0]  idx;
    val = s.cmd.byte_w ? {8'h00, v[7:0]} : v;
    idx = s.cmd.dst_reg - cbsmse_pkg::REG_GP0;
    if (s.cmd.dst_is_reg) begin
      s.done = 1'b1;
      s.st   = cbsmse_pkg::ST_IDLE;
      if (s.cmd.dst_reg == cbsmse_pkg::REG_PC) begin
        s.pc = {4'h0, val};
      end else if (s.cmd.dst_reg == cbsmse_pkg::REG_SP) begin
        s.sp = {4'h0, val};
      end else if (s.cmd.dst_reg == cbsmse_pkg::REG_SR) begin
        s.sr = val;
      end else if (s.cmd.dst_reg != cbsmse_pkg::REG_CG) begin
        s.regs[idx] = val;
      end
    end else begin
      // Byte writes to memory land on the lane the address selects.
      s.mem.req   = 1'b1;
      s.mem.we    = 1'b1;
      s.mem.addr  = s.cmd.dst_addr;
      s.mem.wdata = s.cmd.byte_w ? {v[7:0], v[7:0]} : v;
      s.mem.be    = s.cmd.byte_w ? (s.cmd.dst_addr[0] ? 2'b10 : 2'b01) : 2'b11;
      s.st        = cbsmse_pkg::ST_WR;
    end
    return s;
  endfunction

  // Next-state logic of the whole execution unit.
  always_comb begin
    n      = q;
    n.done = 1'b0;
    case (i_rd_sel)
      cbsmse_pkg::REG_PC: n.rd_data = q.pc[15:0];
      cbsmse_pkg::REG_SP: n.rd_data = q.sp[15:0];
      cbsmse_pkg::REG_SR: n.rd_data = q.sr;
      cbsmse_pkg::REG_CG: n.rd_data = 16'h0000;
      default:            n.rd_data = q.regs[rd_idx];
    endcase
    case (q.st)
      cbsmse_pkg::ST_IDLE: begin
        if (acc) begin
          n.cmd = i_cmd;
          case (i_cmd.op)
            cbsmse_pkg::OP_BRANCH_IF_NONZERO: begin
              // Status word is never written here.
              if (!q.sr[cbsmse_pkg::SR_Z]) begin
                n.pc = q.pc + jump_ofs;
              end
              n.done = 1'b1;
            end
            cbsmse_pkg::OP_COPY_OP: begin
              n = put_dst(n, i_cmd.src);
            end
            cbsmse_pkg::OP_STACK_PUSH: begin
              n.sp        = q.sp - cbsmse_pkg::SP_STEP;
              n.mem.req   = 1'b1;
              n.mem.we    = 1'b1;
              n.mem.addr  = q.sp - cbsmse_pkg::SP_STEP;
              n.mem.wdata = i_cmd.byte_w ? {8'h00, i_cmd.src[7:0]} : i_cmd.src;
              n.mem.be    = i_cmd.byte_w ? 2'b01 : 2'b11;
              n.st        = cbsmse_pkg::ST_WR;
            end
            cbsmse_pkg::OP_STACK_PULL,
            cbsmse_pkg::OP_SUBROUTINE_EXIT_OP,
            cbsmse_pkg::OP_INTERRUPT_EXIT_OP: begin
              n.mem.req  = 1'b1;
              n.mem.we   = 1'b0;
              n.mem.addr = q.sp;
              n.mem.be   = 2'b11;
              n.st       = cbsmse_pkg::ST_RD1;
            end
            cbsmse_pkg::OP_ARITH_SHIFT_LEFT_OP: begin
              // Mode bits are left alone; only the four flags move.
              n.sr[cbsmse_pkg::SR_C] = i_cmd.byte_w ? i_cmd.dst_val[7]
                                                    : i_cmd.dst_val[15];
              n.sr[cbsmse_pkg::SR_V] = sh_ovf;
              n.sr[cbsmse_pkg::SR_N] = i_cmd.byte_w ? sh_res[7] : sh_res[15];
              n.sr[cbsmse_pkg::SR_Z] = (sh_res == 16'h0000);
              n = put_dst(n, sh_res);
            end
            default: begin
              n.done = 1'b1;
            end
          endcase
        end
      end
      cbsmse_pkg::ST_RD1: begin
        if (i_mem_ack) begin
          n.sp      = q.sp + cbsmse_pkg::SP_STEP;
          n.mem.req = 1'b0;
          n.st      = cbsmse_pkg::ST_IDLE;
          case (q.cmd.op)
            cbsmse_pkg::OP_SUBROUTINE_EXIT_OP: begin
              n.pc   = {4'h0, i_mem_rdata};
              n.done = 1'b1;
            end
            cbsmse_pkg::OP_INTERRUPT_EXIT_OP: begin
              // Top nibble of the saved word carries the high pc bits.
              n.sr       = {4'h0, i_mem_rdata[11:0]};
              n.hi_pc    = i_mem_rdata[15:12];
              n.mem.req  = 1'b1;
              n.mem.addr = q.sp + cbsmse_pkg::SP_STEP;
              n.st       = cbsmse_pkg::ST_RD2;
            end
            default: begin
              n = put_dst(n, i_mem_rdata);
            end
          endcase
        end
      end
      cbsmse_pkg::ST_RD2: begin
        if (i_mem_ack) begin
          n.pc      = {q.hi_pc, i_mem_rdata};
          n.sp      = q.sp + cbsmse_pkg::SP_STEP;
          n.mem.req = 1'b0;
          n.done    = 1'b1;
          n.st      = cbsmse_pkg::ST_IDLE;
        end
      end
      cbsmse_pkg::ST_WR: begin
        if (i_mem_ack) begin
          n.mem.req = 1'b0;
          n.mem.we  = 1'b0;
          n.done    = 1'b1;
          n.st      = cbsmse_pkg::ST_IDLE;
        end
      end
      default: begin
        n.st = cbsmse_pkg::ST_IDLE;
      end
    endcase
  end

  // State register; the bus request waits in place until acknowledged.
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      q    <= '0;
      q.st <= cbsmse_pkg::ST_IDLE;
      q.pc <= cbsmse_pkg::PC_RST;
      q.sp <= cbsmse_pkg::SP_RST;
      q.sr <= cbsmse_pkg::SR_RST;
    end else begin
      q <= n;
    end
  end

  assign o_done            = q.done;
  assign o_mem             = q.mem;
  assign o_rd_data         = q.rd_data;
  assign o_program_counter = q.pc;
  assign o_stack_pointer   = q.sp;
  assign o_status_word     = q.sr;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  // Checks on the architectural effect of each operation.
  branch_taken_a: assert property (
    acc && i_cmd.op == cbsmse_pkg::OP_BRANCH_IF_NONZERO && !q.sr[cbsmse_pkg::SR_Z]
    |=> q.pc == $past(q.pc) + $past(jump_ofs) && q.done)
    else $error("Branch target wrong.");
  branch_fall_a: assert property (
    acc && i_cmd.op == cbsmse_pkg::OP_BRANCH_IF_NONZERO && q.sr[cbsmse_pkg::SR_Z]
    |=> $stable(q.pc) && q.done)
    else $error("Branch taken with zero set.");
  branch_flags_a: assert property (
    acc && i_cmd.op == cbsmse_pkg::OP_BRANCH_IF_NONZERO
    |=> $stable(q.sr) && $stable(q.sp))
    else $error("Branch changed status word.");
  copy_flags_a: assert property (
    acc && i_cmd.op == cbsmse_pkg::OP_COPY_OP
    && !(i_cmd.dst_is_reg && i_cmd.dst_reg == cbsmse_pkg::REG_SR) |=> $stable(q.sr))
    else $error("Copy changed flags.");
  idle_keep_a: assert property (
    acc && i_cmd.op == cbsmse_pkg::OP_IDLE_OP
    |=> $stable(q.pc) && $stable(q.sp) && $stable(q.sr) && $stable(q.regs) && q.done)
    else $error("Idle changed state.");
  pull_step_a: assert property (
    q.st == cbsmse_pkg::ST_RD1 && i_mem_ack && q.cmd.op == cbsmse_pkg::OP_STACK_PULL
    |=> q.sp == $past(q.sp) + cbsmse_pkg::SP_STEP)
    else $error("Pull step not two.");
  pull_byte_a: assert property (
    q.st == cbsmse_pkg::ST_RD1 && i_mem_ack && q.cmd.op == cbsmse_pkg::OP_STACK_PULL
    && q.cmd.byte_w && q.cmd.dst_is_reg && q.cmd.dst_reg >= cbsmse_pkg::REG_GP0
    |=> q.regs[$past(q.cmd.dst_reg - cbsmse_pkg::REG_GP0)]
    == {8'h00, $past(i_mem_rdata[7:0])})
    else $error("Byte pull left the upper byte set.");
  push_addr_a: assert property (
    acc && i_cmd.op == cbsmse_pkg::OP_STACK_PUSH
    |=> q.sp == $past(q.sp) - cbsmse_pkg::SP_STEP && o_mem.addr == q.sp && o_mem.we
    && o_mem.be == ($past(i_cmd.byte_w) ? 2'b01 : 2'b11))
    else $error("Push address or lanes wrong.");
  sub_exit_a: assert property (
    q.st == cbsmse_pkg::ST_RD1 && i_mem_ack
    && q.cmd.op == cbsmse_pkg::OP_SUBROUTINE_EXIT_OP
    |=> q.pc == {4'h0, $past(i_mem_rdata)} && q.done)
    else $error("Subroutine exit pc wrong.");
  // The two stack reads of an interrupt exit are checked one at a time, since the bus
  // may stall for any number of cycles between them.
  irq_status_a: assert property (
    q.st == cbsmse_pkg::ST_RD1 && i_mem_ack
    && q.cmd.op == cbsmse_pkg::OP_INTERRUPT_EXIT_OP
    |=> q.sr == {4'h0, $past(i_mem_rdata[11:0])} && q.hi_pc == $past(i_mem_rdata[15:12])
    && q.sp == $past(q.sp) + cbsmse_pkg::SP_STEP && o_mem.req && o_mem.addr == q.sp)
    else $error("Interrupt exit status restore wrong.");
  irq_exit_a: assert property (
    q.st == cbsmse_pkg::ST_RD2 && i_mem_ack
    |=> q.pc == {$past(q.hi_pc), $past(i_mem_rdata)}
    && q.sp == $past(q.sp) + cbsmse_pkg::SP_STEP && q.done)
    else $error("Interrupt exit return wrong.");
  shift_carry_a: assert property (
    acc && i_cmd.op == cbsmse_pkg::OP_ARITH_SHIFT_LEFT_OP
    |=> q.sr[cbsmse_pkg::SR_C] == ($past(i_cmd.byte_w) ? $past(i_cmd.dst_val[7])
                                                        : $past(i_cmd.dst_val[15])))
    else $error("Shift carry wrong.");
  shift_ovf_a: assert property (
    acc && i_cmd.op == cbsmse_pkg::OP_ARITH_SHIFT_LEFT_OP && !i_cmd.byte_w
    |=> q.sr[cbsmse_pkg::SR_V] == ($past(i_cmd.dst_val) >= cbsmse_pkg::OVF_W_LO
    && $past(i_cmd.dst_val) < cbsmse_pkg::OVF_W_HI))
    else $error("Word shift overflow wrong.");
  byte_ovf_a: assert property (
    acc && i_cmd.op == cbsmse_pkg::OP_ARITH_SHIFT_LEFT_OP && i_cmd.byte_w
    |=> q.sr[cbsmse_pkg::SR_V] == ($past(i_cmd.dst_val[7:0]) >= cbsmse_pkg::OVF_B_LO
    && $past(i_cmd.dst_val[7:0]) < cbsmse_pkg::OVF_B_HI))
    else $error("Byte shift overflow wrong.");
  shift_mode_a: assert property (
    acc && i_cmd.op == cbsmse_pkg::OP_ARITH_SHIFT_LEFT_OP
    && !(i_cmd.dst_is_reg && i_cmd.dst_reg == cbsmse_pkg::REG_SR)
    |=> q.sr[cbsmse_pkg::SR_OSC:cbsmse_pkg::SR_GIE]
    == $past(q.sr[cbsmse_pkg::SR_OSC:cbsmse_pkg::SR_GIE]))
    else $error("Shift changed mode bits.");
  cg_drop_a: assert property (
    acc && i_cmd.op == cbsmse_pkg::OP_COPY_OP && i_cmd.dst_is_reg
    && i_cmd.dst_reg == cbsmse_pkg::REG_CG |=> $stable(q.regs) && $stable(q.pc)
    && $stable(q.sp) && $stable(q.sr))
    else $error("Constant register write kept.");

  // Main scenarios.
  branch_c: cover property (acc && i_cmd.op == cbsmse_pkg::OP_BRANCH_IF_NONZERO);
  irq_exit_c: cover property (q.st == cbsmse_pkg::ST_RD2 && i_mem_ack);
  push_c: cover property (q.st == cbsmse_pkg::ST_WR && i_mem_ack && q.cmd.byte_w);
  pull_byte_c: cover property (q.st == cbsmse_pkg::ST_RD1 && i_mem_ack && q.cmd.byte_w);
  shift_ovf_c: cover property (acc && i_cmd.op == cbsmse_pkg::OP_ARITH_SHIFT_LEFT_OP && sh_ovf);

endmodule // cbsmse_exec

// >>> hw/cbsmse_pkg.sv
package cbsmse_pkg;

  // Status word bit positions.
  localparam int unsigned SR_C    = 0;
  localparam int unsigned SR_Z    = 1;
  localparam int unsigned SR_N    = 2;
  localparam int unsigned SR_GIE  = 3;
  localparam int unsigned SR_HALT = 4;
  localparam int unsigned SR_OSC  = 5;
  localparam int unsigned SR_V    = 8;

  // Reset values and pointer step.
  localparam logic [19:0] PC_RST  = 20'h00000;
  localparam logic [19:0] SP_RST  = 20'h00000;
  localparam logic [15:0] SR_RST  = 16'h0000;
  localparam logic [19:0] SP_STEP = 20'h00002;

  // Overflow windows of the arithmetic left shift.
  localparam logic [15:0] OVF_W_LO = 16'h4000;
  localparam logic [15:0] OVF_W_HI = 16'hC000;
  localparam logic [7:0]  OVF_B_LO = 8'h40;
  localparam logic [7:0]  OVF_B_HI = 8'hC0;

  // Register numbers with special meaning.
  localparam logic [3:0] REG_PC  = 4'h0;
  localparam logic [3:0] REG_SP  = 4'h1;
  localparam logic [3:0] REG_SR  = 4'h2;
  localparam logic [3:0] REG_CG  = 4'h3;
  localparam logic [3:0] REG_GP0 = 4'h4;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_RD1  = 4'h2,
    ST_RD2  = 4'h4,
    ST_WR   = 4'h8
  } cbsmse_state_e;

  typedef enum logic [2:0] {
    OP_BRANCH_IF_NONZERO   = 3'h0,
    OP_COPY_OP             = 3'h1,
    OP_IDLE_OP             = 3'h2,
    OP_STACK_PULL          = 3'h3,
    OP_STACK_PUSH          = 3'h4,
    OP_SUBROUTINE_EXIT_OP  = 3'h5,
    OP_INTERRUPT_EXIT_OP   = 3'h6,
    OP_ARITH_SHIFT_LEFT_OP = 3'h7
  } cbsmse_op_e;

  typedef struct packed {
    cbsmse_op_e  op;
    logic        byte_w;
    logic        dst_is_reg;
    logic [3:0]  dst_reg;
    logic [19:0] dst_addr;
    logic [15:0] src;
    logic [15:0] dst_val;
    logic [9:0]  offset;
  } cbsmse_cmd_s;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [19:0] addr;
    logic [15:0] wdata;
    logic [1:0]  be;
  } cbsmse_mem_s;

endpackage

// >>> test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic                    i_sys_clk;
  logic                    i_resetn;
  logic                    i_cmd_valid;
  cbsmse_pkg::cbsmse_cmd_s i_cmd;
  logic                    o_cmd_ready;
  logic                    o_done;
  cbsmse_pkg::cbsmse_mem_s o_mem;
  logic                    i_mem_ack;
  logic [15:0]             i_mem_rdata;
  logic [3:0]              i_rd_sel;
  logic [15:0]             o_rd_data;
  logic [19:0]             o_program_counter;
  logic [19:0]             o_stack_pointer;
  logic [15:0]             o_status_word;
  int                      error_cnt = 0;
  int                      n_checks = 0;
  int                      cyc = 0;
  int                      stall = 0;
  int                      wait_n = 0;
  logic [15:0]             rd_q[$];
  logic [38:0]             log_q[$];
  logic [15:0]             esr;
  logic [19:0]             epc;

  cbsmse_exec DUT (.i_sys_clk, .i_resetn, .i_cmd_valid, .i_cmd, .o_cmd_ready, .o_done,
    .o_mem, .i_mem_ack, .i_mem_rdata, .i_rd_sel, .o_rd_data, .o_program_counter,
    .o_stack_pointer, .o_status_word);

  // Free-running 100 MHz clock.
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  // A hang is cut short well beyond the under two hundred cycles the tests need.
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      close_out();
    end
  end

  // Bus responder: acks after a chosen stall and logs every completed request.
  // Released read data is inverted so a stale value can never look right.
  always @(negedge i_sys_clk) begin
    if (i_mem_ack) begin
      i_mem_ack = 1'b0;
      i_mem_rdata = ~i_mem_rdata;
    end else if (o_mem.req === 1'b1) begin
      if (wait_n > 0) begin
        wait_n--;
      end else begin
        i_mem_ack = 1'b1;
        i_mem_rdata = o_mem.we ? 16'h0000 : rd_q.pop_front();
        log_q.push_back({o_mem.we, o_mem.addr, o_mem.wdata, o_mem.be});
        wait_n = stall;
      end
    end
  end

  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [38:0] got, input logic [38:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Write data and byte enables are only meaningful on writes, so reads compare address.
  task automatic chk_mem(input logic we, input logic [19:0] a, input logic [15:0] wd,
                         input logic [1:0] be);
    logic [38:0] g;
    g = (log_q.size() > 0) ? log_q.pop_front() : 39'bx;
    chk(g, {we, a, we ? wd : g[17:2], we ? be : g[1:0]});
  endtask

  function automatic cbsmse_pkg::cbsmse_cmd_s mk(input cbsmse_pkg::cbsmse_op_e op,
      input logic bw, input logic [3:0] rg, input logic [15:0] v);
    mk = '0;
    mk.op = op;
    mk.byte_w = bw;
    mk.dst_is_reg = 1'b1;
    mk.dst_reg = rg;
    mk.src = v;
    mk.dst_val = v;
    mk.offset = v[9:0];
  endfunction

  // Offer one command, hold it over the taking edge, then wait for done.
  // Memory operations must refuse further commands until their bus work is over.
  task automatic run(input cbsmse_pkg::cbsmse_cmd_s c);
    int   k;
    logic mem_op;
    mem_op = (c.op inside {cbsmse_pkg::OP_STACK_PULL, cbsmse_pkg::OP_STACK_PUSH,
              cbsmse_pkg::OP_SUBROUTINE_EXIT_OP, cbsmse_pkg::OP_INTERRUPT_EXIT_OP})
             || (!c.dst_is_reg
             && c.op inside {cbsmse_pkg::OP_COPY_OP, cbsmse_pkg::OP_ARITH_SHIFT_LEFT_OP});
    @(negedge i_sys_clk);
    i_cmd = c;
    i_cmd_valid = 1'b1;
    @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_cmd_valid = 1'b0;
    chk(o_cmd_ready, !mem_op);
    for (k = 0; k < 40 && o_done !== 1'b1; k++) @(negedge i_sys_clk);
    chk(k < 40, 1);
    @(negedge i_sys_clk);
    chk(o_done, 1'b0);
  endtask

  task automatic rdchk(input logic [3:0] s, input logic [15:0] e);
    @(negedge i_sys_clk);
    i_rd_sel = s;
    @(negedge i_sys_clk);
    chk(o_rd_data, e);
  endtask

  task automatic t_int_exit();
    run(mk(cbsmse_pkg::OP_COPY_OP, 1'b0, cbsmse_pkg::REG_SP, 16'h0400));
    chk(o_stack_pointer, 20'h00400);
    stall = 2;
    wait_n = 2;
    rd_q = '{16'hA12F, 16'h3456};
    run(mk(cbsmse_pkg::OP_INTERRUPT_EXIT_OP, 1'b0, 4'h0, 16'h0000));
    chk_mem(1'b0, 20'h00400, 16'h0000, 2'b00);
    chk_mem(1'b0, 20'h00402, 16'h0000, 2'b00);
    chk(o_stack_pointer, 20'h00404);
    chk(o_program_counter, 20'hA3456);
    chk(o_status_word, 16'h012F);
    stall = 0;
    wait_n = 0;
  endtask

  // Zero is set after the restore, then cleared by a shift so the branch is taken.
  task automatic t_branch();
    epc = o_program_counter;
    esr = o_status_word;
    run(mk(cbsmse_pkg::OP_BRANCH_IF_NONZERO, 1'b0, 4'h0, 16'h01FF));
    chk(o_program_counter, epc);
    chk(o_status_word, esr);
    run(mk(cbsmse_pkg::OP_ARITH_SHIFT_LEFT_OP, 1'b0, cbsmse_pkg::REG_GP0, 16'h0001));
    chk(o_status_word, 16'h0028);
    run(mk(cbsmse_pkg::OP_BRANCH_IF_NONZERO, 1'b0, 4'h0, 16'h01FF));
    chk(o_program_counter, epc + 20'h003FE);
    run(mk(cbsmse_pkg::OP_BRANCH_IF_NONZERO, 1'b0, 4'h0, 16'h0201));
    chk(o_program_counter, epc);
    chk(o_status_word, 16'h0028);
  endtask

  // Both overflow window edges, word and byte; junk upper byte checks clearing.
  task automatic t_shift();
    logic [15:0] tv[5];
    logic [15:0] v;
    logic [15:0] r;
    logic        c;
    logic        ov;
    tv = '{16'h3FFF, 16'h4000, 16'hBFFF, 16'hC000, 16'h8000};
    for (int bw = 0; bw < 2; bw++) begin
      for (int i = 0; i < 5; i++) begin
        v = bw ? {8'hFF, tv[i][15:8]} : tv[i];
        run(mk(cbsmse_pkg::OP_ARITH_SHIFT_LEFT_OP, bw[0], cbsmse_pkg::REG_GP0, v));
        r = bw ? {8'h00, v[6:0], 1'b0} : {v[14:0], 1'b0};
        c = bw ? v[7] : v[15];
        ov = bw ? (v[7:0] >= 8'h40 && v[7:0] < 8'hC0) : (v >= 16'h4000 && v < 16'hC000);
        esr = 16'h0028 | {7'h00, ov, 5'h00, bw ? r[7] : r[15], r == 16'h0000, c};
        rdchk(cbsmse_pkg::REG_GP0, r);
        chk(o_status_word, esr);
      end
    end
  endtask

  task automatic t_copy();
    cbsmse_pkg::cbsmse_cmd_s c;
    esr = o_status_word;
    epc = o_program_counter;
    run(mk(cbsmse_pkg::OP_COPY_OP, 1'b0, 4'h5, 16'hBEEF));
    rdchk(4'h5, 16'hBEEF);
    c = mk(cbsmse_pkg::OP_COPY_OP, 1'b1, 4'h0, 16'h12AB);
    c.dst_is_reg = 1'b0;
    c.dst_addr = 20'h00201;
    run(c);
    chk_mem(1'b1, 20'h00201, 16'hABAB, 2'b10);
    run(mk(cbsmse_pkg::OP_COPY_OP, 1'b0, cbsmse_pkg::REG_CG, 16'h5A5A));
    rdchk(cbsmse_pkg::REG_CG, 16'h0000);
    run(mk(cbsmse_pkg::OP_IDLE_OP, 1'b0, cbsmse_pkg::REG_CG, 16'h0000));
    chk(o_program_counter, epc);
    chk(o_stack_pointer, 20'h00404);
    chk(o_status_word, esr);
    c = mk(cbsmse_pkg::OP_ARITH_SHIFT_LEFT_OP, 1'b1, 4'h0, 16'h00C1);
    c.dst_is_reg = 1'b0;
    c.dst_addr = 20'h00300;
    run(c);
    chk_mem(1'b1, 20'h00300, 16'h8282, 2'b01);
    chk(o_status_word, 16'h002D);
  endtask

  task automatic t_stack();
    esr = o_status_word;
    run(mk(cbsmse_pkg::OP_STACK_PUSH, 1'b0, 4'h0, 16'h1234));
    chk_mem(1'b1, 20'h00402, 16'h1234, 2'b11);
    run(mk(cbsmse_pkg::OP_STACK_PUSH, 1'b1, 4'h0, 16'h55AA));
    chk_mem(1'b1, 20'h00400, 16'h00AA, 2'b01);
    chk(o_stack_pointer, 20'h00400);
    rd_q = '{16'hCAFE, 16'h77EE, 16'h9ABC};
    run(mk(cbsmse_pkg::OP_STACK_PULL, 1'b0, 4'h7, 16'h0000));
    chk_mem(1'b0, 20'h00400, 16'h0000, 2'b00);
    rdchk(4'h7, 16'hCAFE);
    run(mk(cbsmse_pkg::OP_STACK_PULL, 1'b1, 4'h8, 16'h0000));
    chk_mem(1'b0, 20'h00402, 16'h0000, 2'b00);
    chk(o_stack_pointer, 20'h00404);
    rdchk(4'h8, 16'h00EE);
    run(mk(cbsmse_pkg::OP_SUBROUTINE_EXIT_OP, 1'b0, 4'h0, 16'h0000));
    chk_mem(1'b0, 20'h00404, 16'h0000, 2'b00);
    chk(o_program_counter, 20'h09ABC);
    chk(o_stack_pointer, 20'h00406);
    chk(o_status_word, esr);
  endtask

  // Main sequence: reset, then each scenario in an order that builds on the last.
  initial begin
    i_resetn = 1'b0;
    i_cmd_valid = 1'b0;
    i_cmd = '0;
    i_mem_ack = 1'b0;
    i_mem_rdata = 16'h0000;
    i_rd_sel = 4'h0;
    repeat (20) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_resetn = 1'b1;
    chk(o_program_counter, cbsmse_pkg::PC_RST);
    chk(o_stack_pointer, cbsmse_pkg::SP_RST);
    chk(o_status_word, cbsmse_pkg::SR_RST);
    t_int_exit();
    t_branch();
    t_shift();
    t_copy();
    t_stack();
    close_out();
  end
endmodule // tb_top
